// ### hdl/dmem_pkg.sv
// Constants, types and address functions for the banked data memory block
package dmem_pkg;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 8;
	localparam int BANK_W = 4;
	localparam int OFFS_W = 8;
	localparam int NUM_BANKS = 16;
	localparam int BANK_BYTES = 256;
	localparam int MEM_BYTES = 4096;

	// One bit per bank; a clear bit marks a bank with no storage behind it
	localparam logic [15:0] IMPL_BANK_MASK = 16'hFFFF;
	// Access bank: offsets below the split go to bank 0, the rest to bank F
	localparam logic [7:0] ACCESS_SPLIT = 8'h60;
	localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
	localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
	localparam logic [3:0] BANK_PTR_RST = 4'h0;

	// Avalon-MM register byte offsets
	localparam int AVS_ADDR_W = 4;
	localparam logic [3:0] REG_BANK_PTR = 4'h0;
	localparam logic [3:0] REG_STATUS = 4'h4;
	localparam logic [3:0] REG_DROP_CNT = 4'h8;
	localparam logic [3:0] REG_BANK_MASK = 4'hC;

	// Status word field positions
	localparam int ST_ADDR_LSB = 0;
	localparam int ST_ZERO_BIT = 16;
	localparam int ST_NEG_BIT = 17;
	localparam int ST_HIT_BIT = 18;
	localparam int ST_BUSY_BIT = 19;
	localparam int DROP_CNT_W = 16;

	typedef enum logic [2:0] {
		OP_NONE,
		OP_READ,
		OP_WRITE,
		OP_MOVE,
		OP_LOAD_BANK
	} core_op_t;

	function automatic logic [11:0] banked_addr(input logic [3:0] bank,
		input logic [7:0] offs);
		return {bank, offs};
	endfunction

	function automatic logic [11:0] access_addr(input logic [7:0] offs);
		if (offs < ACCESS_SPLIT)
			return {ACCESS_LO_BANK, offs};
		return {ACCESS_HI_BANK, offs};
	endfunction

	function automatic logic bank_is_impl(input logic [11:0] addr);
		return IMPL_BANK_MASK[addr[11:8]];
	endfunction
endpackage

// ### hdl/ram_port_if.sv
// Port between the address logic and the data memory array
`timescale 1ns/1ps
interface ram_port_if;
	logic [11:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic we;
	logic re;
	modport owner (output addr, output wdata, output we, output re,
		input rdata);
	modport mem (input addr, input wdata, input we, input re,
		output rdata);
endinterface

// ### hdl/bank_addr_gen.sv
// Effective address former for banked, access bank and full addresses
`timescale 1ns/1ps
module bank_addr_gen
	import dmem_pkg::*;
(
	input wire logic [3:0] bank_ptr,
	input wire logic access_sel,
	input wire logic indirect,
	input wire logic [7:0] offset,
	input wire logic [11:0] full_addr,
	output logic [11:0] eff_addr
);
	always_comb begin
		if (indirect)
			eff_addr = full_addr;
		else if (access_sel)
			eff_addr = banked_addr(bank_ptr, offset);
		else
			eff_addr = access_addr(offset);
	end
endmodule

// ### hdl/data_ram.sv
// Byte-wide static data memory with gating for unimplemented banks
`timescale 1ns/1ps
module data_ram
	import dmem_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rstn,
	ram_port_if.mem port
);
	logic [7:0] mem_a [0:MEM_BYTES-1];

	always_ff @(posedge sys_clk) begin
		if (port.we && bank_is_impl(port.addr))
			mem_a[port.addr] <= port.wdata;
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn)
			port.rdata <= 8'h00;
		else if (port.re)
			port.rdata <= bank_is_impl(port.addr) ?
				mem_a[port.addr] : 8'h00;
	end
endmodule

// ### hdl/banked_data_memory_addressing.sv
// Data memory address formation, bank pointer and access control
//
// Local design decisions: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
module banked_data_memory_addressing
	import dmem_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic core_req,
	input wire core_op_t core_op,
	input wire logic core_access_sel,
	input wire logic core_indirect,
	input wire logic [7:0] core_offset,
	input wire logic [11:0] core_full_addr,
	input wire logic [11:0] core_dst_addr,
	input wire logic [7:0] core_literal,
	input wire logic [7:0] core_wdata,
	output logic core_busy,
	output logic core_done,
	output logic [7:0] core_rdata,
	output logic core_zero,
	output logic core_neg,
	output logic core_flags_upd,
	output logic [11:0] core_eff_addr,
	output logic core_hit,
	output logic [3:0] bank_ptr
);
	typedef enum logic [0:0] {
		ST_IDLE,
		ST_MOVE_WR
	} move_state_t;

	move_state_t state_r;
	move_state_t state_nxt;
	logic [3:0] bank_ptr_r;
	logic [11:0] move_dst_r;
	logic [11:0] banked_eff;
	logic take;
	logic drop_evt;

	// Stage between the array access and the result outputs
	logic s1_valid_r;
	logic s1_from_ram_r;
	logic s1_flags_r;
	logic [7:0] s1_val_r;
	logic [11:0] s1_addr_r;
	logic s1_hit_r;

	logic core_busy_r;
	logic core_done_r;
	logic [7:0] core_rdata_r;
	logic core_zero_r;
	logic core_neg_r;
	logic core_flags_upd_r;
	logic [11:0] core_eff_addr_r;
	logic core_hit_r;

	logic avs_wait_r;
	logic [31:0] avs_rdata_r;
	logic avs_req;
	logic avs_wr_take;
	logic [DROP_CNT_W-1:0] drop_cnt_r;
	logic [DROP_CNT_W-1:0] drop_cnt_nxt;
	logic drop_clr;
	logic [7:0] result_val;

	// Next values and decoded strobes
	logic [3:0] bank_ptr_nxt;
	logic bank_wr;
	logic load_take;
	logic move_take;
	logic flags_upd;
	logic avs_wait_nxt;
	logic [31:0] status_word;
	logic [31:0] avs_rdata_nxt;

	ram_port_if ram ();

	data_ram u_ram (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.port(ram.mem)
	);

	// Every non-move instruction goes through this former
	bank_addr_gen u_addr (
		.bank_ptr(bank_ptr_r),
		.access_sel(core_access_sel),
		.indirect(core_indirect),
		.offset(core_offset),
		.full_addr(core_full_addr),
		.eff_addr(banked_eff)
	);

	// A request while a move is in flight is ignored, not queued
	assign take = core_req && (state_r == ST_IDLE);
	// Move and load are decoded once: move latches the destination, load steers the bank pointer
	assign load_take = take && core_op == OP_LOAD_BANK;
	assign move_take = take && core_op == OP_MOVE;

	always_comb begin
		ram.addr = banked_eff;
		ram.wdata = core_wdata;
		ram.we = 1'b0;
		ram.re = 1'b0;
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: begin
				if (take) begin
					case (core_op)
						OP_READ: begin
							ram.re = 1'b1;
						end
						OP_WRITE: begin
							ram.we = 1'b1;
						end
						OP_MOVE: begin
							ram.addr = core_full_addr;
							ram.re = 1'b1;
							state_nxt = ST_MOVE_WR;
						end
						default: begin
							ram.re = 1'b0;
						end
					endcase
				end
			end
			ST_MOVE_WR: begin
				ram.addr = move_dst_r;
				ram.wdata = ram.rdata;
				ram.we = 1'b1;
				state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			state_r <= ST_IDLE;
			core_busy_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			core_busy_r <= (state_nxt != ST_IDLE);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn)
			move_dst_r <= 12'h000;
		else if (move_take)
			move_dst_r <= core_dst_addr;
	end

	// Only byte lane 0 carries the implemented pointer bits
	assign bank_wr = avs_wr_take && avs_address == REG_BANK_PTR &&
		avs_byteenable[0];

	// The literal load wins over a bus write landing in the same cycle
	always_comb begin
		bank_ptr_nxt = bank_ptr_r;
		if (load_take)
			bank_ptr_nxt = core_literal[3:0];
		else if (bank_wr)
			bank_ptr_nxt = avs_writedata[3:0];
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn)
			bank_ptr_r <= BANK_PTR_RST;
		else
			bank_ptr_r <= bank_ptr_nxt;
	end

	// Stage 1 captures what the result outputs need one edge later
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			s1_valid_r <= 1'b0;
			s1_from_ram_r <= 1'b0;
			s1_flags_r <= 1'b0;
			s1_val_r <= 8'h00;
			s1_addr_r <= 12'h000;
			s1_hit_r <= 1'b0;
		end else if (state_r == ST_MOVE_WR) begin
			s1_valid_r <= 1'b1;
			s1_from_ram_r <= 1'b0;
			s1_flags_r <= 1'b1;
			s1_val_r <= ram.rdata;
			s1_addr_r <= move_dst_r;
			s1_hit_r <= bank_is_impl(move_dst_r);
		end else if (take && core_op != OP_MOVE && core_op != OP_NONE) begin
			s1_valid_r <= 1'b1;
			s1_from_ram_r <= (core_op == OP_READ);
			s1_flags_r <= (core_op != OP_LOAD_BANK);
			s1_val_r <= (core_op == OP_LOAD_BANK) ?
				{4'h0, core_literal[3:0]} : core_wdata;
			s1_addr_r <= banked_eff;
			s1_hit_r <= bank_is_impl(banked_eff);
		end else begin
			s1_valid_r <= 1'b0;
		end
	end

	// A dropped write still reports the value it carried
	assign result_val = s1_from_ram_r ? ram.rdata : s1_val_r;

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			core_done_r <= 1'b0;
			core_rdata_r <= 8'h00;
			core_eff_addr_r <= 12'h000;
			core_hit_r <= 1'b0;
		end else begin
			core_done_r <= s1_valid_r;
			if (s1_valid_r) begin
				core_rdata_r <= result_val;
				core_eff_addr_r <= s1_addr_r;
				core_hit_r <= s1_hit_r;
			end
		end
	end

	// Flags follow the data whether or not the bank really exists
	assign flags_upd = s1_valid_r && s1_flags_r;

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			core_zero_r <= 1'b0;
			core_neg_r <= 1'b0;
			core_flags_upd_r <= 1'b0;
		end else begin
			core_flags_upd_r <= flags_upd;
			if (flags_upd) begin
				core_zero_r <= (result_val == 8'h00);
				core_neg_r <= result_val[7];
			end
		end
	end

	// Counter of writes discarded at unimplemented banks
	assign drop_evt = ram.we && !bank_is_impl(ram.addr);
	assign drop_clr = avs_wr_take && avs_address == REG_DROP_CNT;

	// An event in the clearing cycle is kept: it counts as one
	always_comb begin
		drop_cnt_nxt = drop_cnt_r;
		if (drop_clr)
			drop_cnt_nxt = '0;
		if (drop_evt && drop_cnt_nxt != {DROP_CNT_W{1'b1}})
			drop_cnt_nxt = drop_cnt_nxt + 1'b1;
	end

	// Saturating, so a long run of drops never wraps back to zero
	always_ff @(posedge sys_clk) begin
		if (!rstn)
			drop_cnt_r <= '0;
		else
			drop_cnt_r <= drop_cnt_nxt;
	end

	// Avalon slave: waitrequest drops for exactly one cycle per request
	assign avs_req = avs_read || avs_write;
	assign avs_wr_take = avs_write && !avs_wait_r;
	// Held high at idle so every request sees exactly one wait state
	assign avs_wait_nxt = !(avs_req && avs_wait_r);

	always_ff @(posedge sys_clk) begin
		if (!rstn)
			avs_wait_r <= 1'b1;
		else
			avs_wait_r <= avs_wait_nxt;
	end

	// Status snapshot of the last finished core operation
	always_comb begin
		status_word = 32'h00000000;
		status_word[ST_ADDR_LSB +: 12] = core_eff_addr_r;
		status_word[ST_ZERO_BIT] = core_zero_r;
		status_word[ST_NEG_BIT] = core_neg_r;
		status_word[ST_HIT_BIT] = core_hit_r;
		status_word[ST_BUSY_BIT] = core_busy_r;
	end

	// Unmapped offsets read zero so software can probe safely
	always_comb begin
		case (avs_address)
			REG_BANK_PTR: begin
				avs_rdata_nxt = {28'h0000000, bank_ptr_r};
			end
			REG_STATUS: begin
				avs_rdata_nxt = status_word;
			end
			REG_DROP_CNT: begin
				avs_rdata_nxt = {16'h0000, drop_cnt_r};
			end
			REG_BANK_MASK: begin
				avs_rdata_nxt = {16'h0000, IMPL_BANK_MASK};
			end
			default: begin
				avs_rdata_nxt = 32'h00000000;
			end
		endcase
	end

	// Read data is latched as waitrequest falls and stands with it
	always_ff @(posedge sys_clk) begin
		if (!rstn)
			avs_rdata_r <= 32'h00000000;
		else if (avs_read && avs_wait_r)
			avs_rdata_r <= avs_rdata_nxt;
	end

	assign avs_readdata = avs_rdata_r;
	assign avs_waitrequest = avs_wait_r;
	assign core_busy = core_busy_r;
	assign core_done = core_done_r;
	assign core_rdata = core_rdata_r;
	assign core_zero = core_zero_r;
	assign core_neg = core_neg_r;
	assign core_flags_upd = core_flags_upd_r;
	assign core_eff_addr = core_eff_addr_r;
	assign core_hit = core_hit_r;
	assign bank_ptr = bank_ptr_r;
endmodule

// ### tb/bdma_sva.sv
// Port-level checks for the banked data memory addressing block
`timescale 1ns/1ps
module bdma_sva
	import dmem_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rstn,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic core_req,
	input wire core_op_t core_op,
	input wire logic core_access_sel,
	input wire logic core_indirect,
	input wire logic [7:0] core_offset,
	input wire logic [11:0] core_full_addr,
	input wire logic [11:0] core_dst_addr,
	input wire logic [7:0] core_literal,
	input wire logic core_busy,
	input wire logic core_done,
	input wire logic core_flags_upd,
	input wire logic [11:0] core_eff_addr,
	input wire logic core_hit,
	input wire logic [3:0] bank_ptr
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	logic take;
	logic rw;
	assign take = core_req && !core_busy;
	assign rw = core_op inside {OP_READ, OP_WRITE};
	sequence move_s;
		core_busy ##1 !core_busy ##1 core_done;
	endsequence
	chk_wait_one: assert property (
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
	chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("bus answer too long");
	chk_ptr_read: assert property (
		!avs_waitrequest && avs_read && avs_address == REG_BANK_PTR
		|-> avs_readdata == {28'h0000000, bank_ptr})
		else $error("bank pointer read wrong");
	chk_load_ptr: assert property (
		take && core_op == OP_LOAD_BANK |=> bank_ptr == $past(core_literal[3:0]))
		else $error("load bank missed");
	chk_done_two: assert property (
		take && (rw || core_op == OP_LOAD_BANK) |-> ##2 core_done)
		else $error("done not two cycles after request");
	chk_banked_addr: assert property (
		take && rw && !core_indirect && core_access_sel |-> ##2
		core_eff_addr == {$past(bank_ptr, 2), $past(core_offset, 2)})
		else $error("banked address wrong");
	chk_access_map: assert property (
		take && rw && !core_indirect && !core_access_sel |-> ##2
		core_eff_addr[7:0] == $past(core_offset, 2) &&
		core_eff_addr[11:8] == ($past(core_offset, 2) < ACCESS_SPLIT ?
		ACCESS_LO_BANK : ACCESS_HI_BANK))
		else $error("access bank address wrong");
	chk_full_addr: assert property (
		take && rw && core_indirect |-> ##2
		core_eff_addr == $past(core_full_addr, 2))
		else $error("full address wrong");
	chk_move_dst: assert property (
		take && core_op == OP_MOVE |=> move_s ##0
		core_eff_addr == $past(core_dst_addr, 3))
		else $error("move sequence wrong");
	chk_flags_done: assert property (core_flags_upd |-> core_done)
		else $error("flag update without done");
	chk_hit_mask: assert property (
		core_flags_upd |-> core_hit == IMPL_BANK_MASK[core_eff_addr[11:8]])
		else $error("hit disagrees with bank mask");
endmodule

// ### tb/core_model.sv
// Instruction execution side that issues data memory operations
`timescale 1ns/1ps
module core_model
	import dmem_pkg::*;
(
	input wire logic sys_clk,
	input wire logic core_done,
	output logic core_req,
	output core_op_t core_op,
	output logic core_access_sel,
	output logic core_indirect,
	output logic [7:0] core_offset,
	output logic [11:0] core_full_addr,
	output logic [11:0] core_dst_addr,
	output logic [7:0] core_literal,
	output logic [7:0] core_wdata
);
	initial begin
		core_req = 1'b0;
		core_op = OP_NONE;
		{core_access_sel, core_indirect, core_offset} = '0;
		{core_full_addr, core_dst_addr, core_literal, core_wdata} = '0;
	end
	// One operation at a time, so a request never lands while busy
	task automatic issue(input core_op_t o, input logic s, i,
		input logic [7:0] off, input logic [11:0] fa, da,
		input logic [7:0] lw, output logic ok);
		int n;
		core_req <= 1'b1;
		core_op <= o;
		core_access_sel <= s;
		core_indirect <= i;
		core_offset <= off;
		core_full_addr <= fa;
		core_dst_addr <= da;
		core_literal <= lw;
		core_wdata <= lw;
		@(posedge sys_clk);
		core_req <= 1'b0;
		core_offset <= ~off;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (core_done !== 1'b1 && n < 20);
		ok = core_done === 1'b1;
	endtask
endmodule

// ### tb/banked_data_memory_addressing_bench.sv
// Self-checking bench for the banked data memory addressing block
`timescale 1ns/1ps
module banked_data_memory_addressing_bench
	import dmem_pkg::*;
;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hF;
	logic [31:0] avs_readdata;
	logic avs_waitrequest, core_req, core_access_sel, core_indirect;
	core_op_t core_op;
	logic [7:0] core_offset, core_literal, core_wdata, core_rdata;
	logic [11:0] core_full_addr, core_dst_addr, core_eff_addr;
	logic core_busy, core_done, core_zero, core_neg, core_flags_upd;
	logic core_hit;
	logic [3:0] bank_ptr;
	int miscompares = 0;
	int checked = 0;
	banked_data_memory_addressing banked_data_memory_addressing_i (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.core_req(core_req),
		.core_op(core_op),
		.core_access_sel(core_access_sel),
		.core_indirect(core_indirect),
		.core_offset(core_offset),
		.core_full_addr(core_full_addr),
		.core_dst_addr(core_dst_addr),
		.core_literal(core_literal),
		.core_wdata(core_wdata),
		.core_busy(core_busy),
		.core_done(core_done),
		.core_rdata(core_rdata),
		.core_zero(core_zero),
		.core_neg(core_neg),
		.core_flags_upd(core_flags_upd),
		.core_eff_addr(core_eff_addr),
		.core_hit(core_hit),
		.bank_ptr(bank_ptr)
	);
	core_model core_model_i (
		.sys_clk(sys_clk),
		.core_done(core_done),
		.core_req(core_req),
		.core_op(core_op),
		.core_access_sel(core_access_sel),
		.core_indirect(core_indirect),
		.core_offset(core_offset),
		.core_full_addr(core_full_addr),
		.core_dst_addr(core_dst_addr),
		.core_literal(core_literal),
		.core_wdata(core_wdata)
	);
	always #4 sys_clk = ~sys_clk;
	task automatic chk(input logic [31:0] s, e);
		checked++;
		if (s !== e) begin
			miscompares++;
			$display("ERROR %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic complete_run;
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic av(input logic w, input logic [3:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		n = 0;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		if (avs_waitrequest !== 1'b0)
			miscompares++;
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic op(input core_op_t o, input logic s, i,
		input logic [7:0] off, input logic [11:0] fa, da,
		input logic [7:0] lw);
		logic ok;
		core_model_i.issue(o, s, i, off, fa, da, lw, ok);
		if (!ok)
			miscompares++;
	endtask
	task automatic s_regs;
		logic [31:0] q;
		av(1'b0, REG_BANK_PTR, 32'h0, q);
		chk(q, {28'h0, BANK_PTR_RST});
		av(1'b1, REG_BANK_PTR, 32'hFFFF_FFA9, q);
		av(1'b0, REG_BANK_PTR, 32'h0, q);
		chk(q, 32'h9);
		av(1'b0, 4'h1, 32'h0, q);
		chk(q, 32'h0);
	endtask
	task automatic s_load;
		logic [31:0] q;
		op(OP_LOAD_BANK, 1'b1, 1'b0, 8'h00, 12'h0, 12'h0, 8'hA7);
		chk(core_rdata, 8'h07);
		chk(core_flags_upd, 1'b0);
		av(1'b0, REG_BANK_PTR, 32'h0, q);
		chk(q, 32'h7);
	endtask
	task automatic s_bank;
		op(OP_WRITE, 1'b1, 1'b0, 8'h35, 12'h0, 12'h0, 8'h80);
		chk(core_eff_addr, 12'h735);
		chk(core_neg, 1'b1);
		chk(core_flags_upd, 1'b1);
		op(OP_READ, 1'b0, 1'b1, 8'h00, 12'h735, 12'h0, 8'h00);
		chk(core_rdata, 8'h80);
		chk(core_hit, IMPL_BANK_MASK[7]);
	endtask
	task automatic s_access;
		op(OP_WRITE, 1'b0, 1'b0, 8'h5F, 12'h0, 12'h0, 8'h00);
		chk(core_eff_addr, 12'h05F);
		chk(core_zero, 1'b1);
		op(OP_READ, 1'b0, 1'b0, 8'h60, 12'h0, 12'h0, 8'h00);
		chk(core_eff_addr, 12'hF60);
	endtask
	task automatic s_move;
		op(OP_LOAD_BANK, 1'b1, 1'b0, 8'h00, 12'h0, 12'h0, 8'h02);
		op(OP_MOVE, 1'b1, 1'b0, 8'h35, 12'h735, 12'hFFF, 8'h00);
		chk(core_eff_addr, 12'hFFF);
		chk(core_rdata, 8'h80);
		op(OP_READ, 1'b0, 1'b1, 8'h00, 12'hFFF, 12'h0, 8'h00);
		chk(core_rdata, 8'h80);
	endtask
	task automatic s_status;
		logic [31:0] q;
		logic [31:0] e;
		e = 32'h00000000;
		e[ST_ADDR_LSB +: 12] = 12'hFFF;
		e[ST_NEG_BIT] = 1'b1;
		e[ST_HIT_BIT] = IMPL_BANK_MASK[15];
		av(1'b0, REG_STATUS, 32'h0, q);
		chk(q, e);
		av(1'b0, REG_BANK_MASK, 32'h0, q);
		chk(q, {16'h0000, IMPL_BANK_MASK});
		e = 32'h00000000;
		if (!IMPL_BANK_MASK[7])
			e++;
		if (!IMPL_BANK_MASK[0])
			e++;
		if (!IMPL_BANK_MASK[15])
			e++;
		av(1'b0, REG_DROP_CNT, 32'h0, q);
		chk(q, e);
		av(1'b1, REG_DROP_CNT, 32'h0, q);
		av(1'b0, REG_DROP_CNT, 32'h0, q);
		chk(q, 32'h0);
	endtask
	initial begin
		#(8 * 4000);
		miscompares++;
		complete_run();
	end
	initial begin
		repeat (8) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		s_regs();
		s_load();
		s_bank();
		s_access();
		s_move();
		s_status();
		complete_run();
	end
endmodule
bind banked_data_memory_addressing bdma_sva bdma_sva_i (
	.sys_clk(sys_clk),
	.rstn(rstn),
	.avs_address(avs_address),
	.avs_read(avs_read),
	.avs_write(avs_write),
	.avs_readdata(avs_readdata),
	.avs_waitrequest(avs_waitrequest),
	.core_req(core_req),
	.core_op(core_op),
	.core_access_sel(core_access_sel),
	.core_indirect(core_indirect),
	.core_offset(core_offset),
	.core_full_addr(core_full_addr),
	.core_dst_addr(core_dst_addr),
	.core_literal(core_literal),
	.core_busy(core_busy),
	.core_done(core_done),
	.core_flags_upd(core_flags_upd),
	.core_eff_addr(core_eff_addr),
	.core_hit(core_hit),
	.bank_ptr(bank_ptr)
);
